// ==== core/dca_access_core.sv ====
`timescale 1ns/1ps
`include "dca_regs.svh"

// How it works
// - Writing one to master control bit 7 starts a core reset; zero does nothing.
// - The core-reset request bit clears itself one cycle after the reset pulse ends.
// - Three operand bytes form one 24-bit value: upper, high, low.
// - Commands needing fewer bits use only the low bits of the operand.
// - Command register sits at 16h right after operand registers 13h to 15h.
// - A write to the command register executes the command at once.
// - Register read commands place the value in the three read-result registers; a memory read fills only the low one.
// - Write commands take their value from the three operand registers.
// - Codes 00 to 07 read base/F/A, BC, DE, HL, IX, IY, SP, PC.
// - Codes 80 to 87 write the same registers from the operand.
// - Codes 06/86 use long or short stack pointer by mode; 08 sets, 09 clears mode.
// - Code 0B reads and 8B writes memory at PC, then PC increments.
module dca_access_core #(
   parameter int CORE_RST_CYCLES = `DCA_CORE_RST_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        dbg_wr,
   input  wire logic [7:0]  dbg_addr,
   input  wire logic [7:0]  dbg_wdata,
   output logic [7:0]       read_result_upper,
   output logic [7:0]       read_result_high,
   output logic [7:0]       read_result_low,
   output logic             read_done,
   output logic             busy,
   output logic             core_reset_request,
   output logic             core_rst,
   output logic             long_address_mode_flag,
   output logic             mem_req,
   output logic             mem_we,
   output logic [23:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack
);
   import dca_pkg::*;

   if (CORE_RST_CYCLES < 1 || CORE_RST_CYCLES > 65535)
   begin : g_cycles_check
      $error("dca_access_core: CORE_RST_CYCLES out of range");
   end

   // ------------------------------------------------------------------
   // Register write decode
   // ------------------------------------------------------------------
   logic wr_master;
   logic wr_upper;
   logic wr_high;
   logic wr_low;
   logic wr_cmd;

   assign wr_master = dbg_wr && dbg_addr == `DCA_ADDR_MASTER_CTL;
   assign wr_upper  = dbg_wr && dbg_addr == `DCA_ADDR_WR_UPPER;
   assign wr_high   = dbg_wr && dbg_addr == `DCA_ADDR_WR_HIGH;
   assign wr_low    = dbg_wr && dbg_addr == `DCA_ADDR_WR_LOW;
   assign wr_cmd    = dbg_wr && dbg_addr == `DCA_ADDR_CMD;

   // ------------------------------------------------------------------
   // Master control and core reset
   // ------------------------------------------------------------------
   logic reset_start;
   logic reset_done;
   logic reset_req_reg;
   logic reset_req_next;

   // Only bit 7 has an effect; the reserved bits are not stored.
   assign reset_start = wr_master && dbg_wdata[`DCA_MASTER_RESET_BIT];

   // A fresh request in the cycle the old one ends keeps the bit set.
   always_comb
   begin
      reset_req_next = reset_req_reg;
      if (reset_start)
         reset_req_next = 1'b1;
      else if (reset_done)
         reset_req_next = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         reset_req_reg <= 1'(`DCA_MASTER_CTL_RESET >> `DCA_MASTER_RESET_BIT);
      else
         reset_req_reg <= reset_req_next;
   end

   dca_core_reset_seq #(
      .CYCLES (CORE_RST_CYCLES)
   ) u_reset_seq (
      .clk      (clk),
      .rst      (rst),
      .start    (reset_start),
      .core_rst (core_rst),
      .done     (reset_done)
   );

   assign core_reset_request = reset_req_reg;

   // ------------------------------------------------------------------
   // Write operand
   // ------------------------------------------------------------------
   logic [7:0]  op_upper_reg;
   logic [7:0]  op_high_reg;
   logic [7:0]  op_low_reg;
   logic [7:0]  op_upper_next;
   logic [7:0]  op_high_next;
   logic [7:0]  op_low_next;
   logic [23:0] operand;

   always_comb
   begin
      op_upper_next = wr_upper ? dbg_wdata : op_upper_reg;
      op_high_next  = wr_high ? dbg_wdata : op_high_reg;
      op_low_next   = wr_low ? dbg_wdata : op_low_reg;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         op_upper_reg <= `DCA_OPERAND_RESET;
         op_high_reg  <= `DCA_OPERAND_RESET;
         op_low_reg   <= `DCA_OPERAND_RESET;
      end
      else
      begin
         op_upper_reg <= op_upper_next;
         op_high_reg  <= op_high_next;
         op_low_reg   <= op_low_next;
      end
   end

   assign operand = {op_upper_reg, op_high_reg, op_low_reg};

   // ------------------------------------------------------------------
   // CPU register view
   // ------------------------------------------------------------------
   logic            rf_wr_en;
   logic            rf_rd_en;
   dca_reg_sel_type rf_sel;
   logic            rf_mode_set;
   logic            rf_mode_clr;
   logic            rf_pc_inc;
   logic [23:0]     rf_rd_data;
   logic            rf_rd_valid;
   logic [23:0]     rf_pc;
   logic [7:0]      rf_base_page;

   dca_cpu_regfile u_regfile (
      .clk                    (clk),
      .rst                    (rst),
      .core_rst               (core_rst),
      .wr_en                  (rf_wr_en),
      .rd_en                  (rf_rd_en),
      .sel                    (rf_sel),
      .wr_data                (operand),
      .mode_set               (rf_mode_set),
      .mode_clr               (rf_mode_clr),
      .pc_inc                 (rf_pc_inc),
      .rd_data                (rf_rd_data),
      .rd_valid               (rf_rd_valid),
      .long_address_mode_flag (long_address_mode_flag),
      .pc                     (rf_pc),
      .base_page_register     (rf_base_page)
   );

   // ------------------------------------------------------------------
   // Command execution
   // ------------------------------------------------------------------
   dca_state_type state_reg;
   dca_state_type state_next;
   logic [7:0]    res_upper_reg;
   logic [7:0]    res_high_reg;
   logic [7:0]    res_low_reg;
   logic [7:0]    res_upper_next;
   logic [7:0]    res_high_next;
   logic [7:0]    res_low_next;
   logic          done_reg;
   logic          done_next;
   logic          mem_we_reg;
   logic          mem_we_next;
   logic [23:0]   mem_addr_reg;
   logic [23:0]   mem_addr_next;
   logic [7:0]    mem_wdata_reg;
   logic [7:0]    mem_wdata_next;
   logic          cmd_take;
   logic          cmd_write;
   logic [6:0]    cmd_code;
   logic [23:0]   pc_address;

   // Commands are dropped while a previous one runs or the core is in reset;
   // the host sees that through busy.
   assign cmd_take  = wr_cmd && state_reg == DCA_ST_IDLE && !core_rst;
   assign cmd_write = dbg_wdata[`DCA_CMD_WRITE_BIT];
   assign cmd_code  = dbg_wdata[6:0];
   assign rf_sel    = dca_reg_sel_type'(dbg_wdata[2:0]);

   // In short mode the page register supplies the top address byte.
   assign pc_address = long_address_mode_flag ? rf_pc : {rf_base_page, rf_pc[15:0]};

   always_comb
   begin
      state_next     = state_reg;
      res_upper_next = res_upper_reg;
      res_high_next  = res_high_reg;
      res_low_next   = res_low_reg;
      done_next      = 1'b0;
      mem_we_next    = mem_we_reg;
      mem_addr_next  = mem_addr_reg;
      mem_wdata_next = mem_wdata_reg;
      rf_wr_en       = 1'b0;
      rf_rd_en       = 1'b0;
      rf_mode_set    = 1'b0;
      rf_mode_clr    = 1'b0;
      rf_pc_inc      = 1'b0;
      unique case (state_reg)
         DCA_ST_IDLE:
         begin
            if (cmd_take)
            begin
               if (cmd_code[6:3] == 4'h0)
               begin
                  if (cmd_write)
                  begin
                     rf_wr_en = 1'b1;
                  end
                  else
                  begin
                     rf_rd_en   = 1'b1;
                     state_next = DCA_ST_REG_READ;
                  end
               end
               else if (cmd_code == `DCA_CMD_SET_MODE && !cmd_write)
               begin
                  rf_mode_set = 1'b1;
               end
               else if (cmd_code == `DCA_CMD_CLR_MODE && !cmd_write)
               begin
                  rf_mode_clr = 1'b1;
               end
               else if (cmd_code == `DCA_CMD_MEMORY)
               begin
                  mem_we_next    = cmd_write;
                  mem_addr_next  = pc_address;
                  mem_wdata_next = op_low_reg;
                  state_next     = DCA_ST_MEMORY;
               end
               // Every other code falls through with no effect.
            end
         end
         DCA_ST_REG_READ:
         begin
            if (rf_rd_valid)
            begin
               res_upper_next = rf_rd_data[23:16];
               res_high_next  = rf_rd_data[15:8];
               res_low_next   = rf_rd_data[7:0];
               done_next      = 1'b1;
               state_next     = DCA_ST_IDLE;
            end
         end
         DCA_ST_MEMORY:
         begin
            if (mem_ack)
            begin
               if (!mem_we_reg)
               begin
                  res_low_next = mem_rdata;
                  done_next    = 1'b1;
               end
               rf_pc_inc  = 1'b1;
               state_next = DCA_ST_IDLE;
            end
         end
         default:
         begin
            state_next = DCA_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg     <= DCA_ST_IDLE;
         res_upper_reg <= `DCA_RESULT_RESET;
         res_high_reg  <= `DCA_RESULT_RESET;
         res_low_reg   <= `DCA_RESULT_RESET;
         done_reg      <= 1'b0;
         mem_we_reg    <= 1'b0;
         mem_addr_reg  <= 24'h000000;
         mem_wdata_reg <= 8'h00;
      end
      else
      begin
         state_reg     <= state_next;
         res_upper_reg <= res_upper_next;
         res_high_reg  <= res_high_next;
         res_low_reg   <= res_low_next;
         done_reg      <= done_next;
         mem_we_reg    <= mem_we_next;
         mem_addr_reg  <= mem_addr_next;
         mem_wdata_reg <= mem_wdata_next;
      end
   end

   assign read_result_upper = res_upper_reg;
   assign read_result_high  = res_high_reg;
   assign read_result_low   = res_low_reg;
   assign read_done         = done_reg;
   assign busy              = state_reg != DCA_ST_IDLE || core_rst;
   assign mem_req           = state_reg == DCA_ST_MEMORY;
   assign mem_we            = mem_we_reg;
   assign mem_addr          = mem_addr_reg;
   assign mem_wdata         = mem_wdata_reg;

endmodule : dca_access_core

// ==== core/dca_regs.svh ====
`ifndef DCA_REGS_SVH
`define DCA_REGS_SVH

// ------------------------------------------------------------------
// Write-only debug register offsets
// ------------------------------------------------------------------
`define DCA_ADDR_MASTER_CTL   8'h11
`define DCA_ADDR_WR_UPPER     8'h13
`define DCA_ADDR_WR_HIGH      8'h14
`define DCA_ADDR_WR_LOW       8'h15
`define DCA_ADDR_CMD          8'h16

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define DCA_MASTER_RESET_BIT  7
`define DCA_MASTER_CTL_RESET  8'h00
`define DCA_OPERAND_RESET     8'h00
`define DCA_RESULT_RESET      8'h00
`define DCA_CMD_WRITE_BIT     7
`define DCA_CPU_REG_RESET     24'h000000

// ------------------------------------------------------------------
// Command codes with the write bit removed
// ------------------------------------------------------------------
`define DCA_CMD_SET_MODE      7'h08
`define DCA_CMD_CLR_MODE      7'h09
`define DCA_CMD_MEMORY        7'h0b

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define DCA_CLK_MHZ           125
`define DCA_CORE_RST_NS       1000
`define DCA_CORE_RST_CYCLES   ((`DCA_CORE_RST_NS * `DCA_CLK_MHZ + 999) / 1000)

`endif

// ==== core/dca_pkg.sv ====
package dca_pkg;

   // Register selected by the low three bits of a register command.
   typedef enum logic [2:0] {
      DCA_SEL_AF = 3'b000,
      DCA_SEL_BC = 3'b001,
      DCA_SEL_DE = 3'b010,
      DCA_SEL_HL = 3'b011,
      DCA_SEL_IX = 3'b100,
      DCA_SEL_IY = 3'b101,
      DCA_SEL_SP = 3'b110,
      DCA_SEL_PC = 3'b111
   } dca_reg_sel_type;

   typedef enum logic [1:0] {
      DCA_ST_IDLE     = 2'b00,
      DCA_ST_REG_READ = 2'b01,
      DCA_ST_MEMORY   = 2'b10
   } dca_state_type;

endpackage : dca_pkg

// ==== core/dca_core_reset_seq.sv ====
`timescale 1ns/1ps
`include "dca_regs.svh"

module dca_core_reset_seq #(
   parameter int CYCLES = `DCA_CORE_RST_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic start,
   output logic      core_rst,
   output logic      done
);

   if (CYCLES < 1 || CYCLES > 65535)
   begin : g_cycles_check
      $error("dca_core_reset_seq: CYCLES out of range");
   end

   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic        active_reg;
   logic        active_next;
   logic        done_reg;
   logic        done_next;

   // A new start while the reset runs restarts the full pulse length.
   always_comb
   begin
      count_next  = count_reg;
      active_next = active_reg;
      done_next   = 1'b0;
      if (start)
      begin
         count_next  = 16'(CYCLES - 1);
         active_next = 1'b1;
      end
      else if (active_reg)
      begin
         if (count_reg == 16'h0000)
         begin
            active_next = 1'b0;
            done_next   = 1'b1;
         end
         else
         begin
            count_next = count_reg - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count_reg  <= 16'h0000;
         active_reg <= 1'b0;
         done_reg   <= 1'b0;
      end
      else
      begin
         count_reg  <= count_next;
         active_reg <= active_next;
         done_reg   <= done_next;
      end
   end

   assign core_rst = active_reg;
   assign done     = done_reg;

endmodule : dca_core_reset_seq

// ==== core/dca_cpu_regfile.sv ====
`timescale 1ns/1ps
`include "dca_regs.svh"

module dca_cpu_regfile (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     core_rst,
   input  wire logic                     wr_en,
   input  wire logic                     rd_en,
   input  wire dca_pkg::dca_reg_sel_type sel,
   input  wire logic [23:0]              wr_data,
   input  wire logic                     mode_set,
   input  wire logic                     mode_clr,
   input  wire logic                     pc_inc,
   output logic [23:0]                   rd_data,
   output logic                          rd_valid,
   output logic                          long_address_mode_flag,
   output logic [23:0]                   pc,
   output logic [7:0]                    base_page_register
);
   import dca_pkg::*;

   // Entries 0..7 follow the select codes; entry 6 is the long stack
   // pointer, the short one lives apart in its own 16 bits.
   logic [23:0] regs_reg [0:7];
   logic [23:0] regs_next [0:7];
   logic [15:0] short_stack_pointer_reg;
   logic [15:0] short_stack_pointer_next;
   logic        mode_reg;
   logic        mode_next;
   logic [23:0] rd_data_reg;
   logic [23:0] rd_data_next;
   logic        rd_valid_reg;

   always_comb
   begin
      for (int i = 0; i < 8; i++)
         regs_next[i] = regs_reg[i];
      short_stack_pointer_next = short_stack_pointer_reg;
      mode_next                = mode_reg;
      rd_data_next             = rd_data_reg;
      if (core_rst)
      begin
         for (int i = 0; i < 8; i++)
            regs_next[i] = `DCA_CPU_REG_RESET;
         short_stack_pointer_next = 16'h0000;
         mode_next                = 1'b0;
      end
      else
      begin
         if (wr_en && sel == DCA_SEL_SP && !mode_reg)
            short_stack_pointer_next = wr_data[15:0];
         else if (wr_en)
            regs_next[sel] = wr_data;
         if (pc_inc)
            regs_next[DCA_SEL_PC] = regs_reg[DCA_SEL_PC] + 24'h000001;
         if (mode_set)
            mode_next = 1'b1;
         else if (mode_clr)
            mode_next = 1'b0;
      end
      if (rd_en && sel == DCA_SEL_SP && !mode_reg)
         rd_data_next = {8'h00, short_stack_pointer_reg};
      else if (rd_en)
         rd_data_next = regs_reg[sel];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < 8; i++)
            regs_reg[i] <= `DCA_CPU_REG_RESET;
         short_stack_pointer_reg <= 16'h0000;
         mode_reg                <= 1'b0;
         rd_data_reg             <= `DCA_CPU_REG_RESET;
         rd_valid_reg            <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
            regs_reg[i] <= regs_next[i];
         short_stack_pointer_reg <= short_stack_pointer_next;
         mode_reg                <= mode_next;
         rd_data_reg             <= rd_data_next;
         rd_valid_reg            <= rd_en;
      end
   end

   assign rd_data                = rd_data_reg;
   assign rd_valid               = rd_valid_reg;
   assign long_address_mode_flag = mode_reg;
   assign pc                     = regs_reg[DCA_SEL_PC];
   assign base_page_register     = regs_reg[DCA_SEL_AF][23:16];

endmodule : dca_cpu_regfile

// ==== test/dca_access_core_assertions.sv ====
`timescale 1ns/1ps

module dca_access_checker #(
   parameter int CORE_RST_CYCLES = 4
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        dbg_wr,
   input wire logic [7:0]  dbg_addr,
   input wire logic [7:0]  dbg_wdata,
   input wire logic [7:0]  read_result_low,
   input wire logic        read_done,
   input wire logic        busy,
   input wire logic        core_reset_request,
   input wire logic        core_rst,
   input wire logic        long_address_mode_flag,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [23:0] mem_addr,
   input wire logic [7:0]  mem_rdata,
   input wire logic        mem_ack
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic        rst_go;
   logic        cmd_go;
   logic [15:0] pulse_cnt_reg;
   logic [15:0] pulse_cnt_next;

   assign rst_go = dbg_wr && dbg_addr == 8'h11 && dbg_wdata[7];
   assign cmd_go = dbg_wr && dbg_addr == 8'h16 && !busy;

   // A restarted pulse is measured afresh.
   always_comb
   begin
      pulse_cnt_next = pulse_cnt_reg;
      if (rst_go)
         pulse_cnt_next = 16'h0000;
      else if (core_rst)
         pulse_cnt_next = pulse_cnt_reg + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         pulse_cnt_reg <= 16'h0000;
      else
         pulse_cnt_reg <= pulse_cnt_next;
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   chk_reset_start: assert property (rst_go |=> core_rst && core_reset_request)
      else $error("core reset did not start");
   chk_zero_idle: assert property (dbg_wr && dbg_addr == 8'h11 && !dbg_wdata[7] && !core_rst
      && !core_reset_request |=> !core_rst && !core_reset_request)
      else $error("core reset started by a zero write");
   chk_pulse_length: assert property ($fell(core_rst) && !$past(rst)
      |-> pulse_cnt_reg == 16'(CORE_RST_CYCLES))
      else $error("core reset pulse has the wrong length");
   chk_request_clears: assert property ($fell(core_rst) && !$past(rst) && !rst_go
      |-> core_reset_request ##1 !core_reset_request)
      else $error("reset request did not clear itself");
   chk_read_timing: assert property (cmd_go && dbg_wdata[7:3] == 5'h00
      |-> ##1 busy && !read_done ##1 read_done && !busy)
      else $error("read command result out of time");
   chk_write_quiet: assert property (cmd_go && dbg_wdata[7] && dbg_wdata[6:3] == 4'h0
      |=> !busy && !read_done)
      else $error("register write command started a read");
   chk_mode_flag: assert property (cmd_go && dbg_wdata[7:1] == 7'h04
      |=> long_address_mode_flag == !$past(dbg_wdata[0]))
      else $error("address mode flag wrong after mode command");
   chk_mem_start: assert property (cmd_go && dbg_wdata[6:0] == 7'h0b
      |=> mem_req && mem_we == $past(dbg_wdata[7]))
      else $error("memory access did not start");
   chk_mem_hold: assert property (mem_req && !mem_ack
      |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request changed before its ack");
   chk_mem_result: assert property (mem_req && mem_ack && !mem_we
      |=> !mem_req && read_done && read_result_low == $past(mem_rdata))
      else $error("memory read byte not delivered");

   cov_read: cover property (read_done);
   cov_mem_write: cover property (mem_req && mem_we && mem_ack);
   cov_core_reset: cover property ($fell(core_rst));
endmodule : dca_access_checker

bind dca_access_core dca_access_checker #(.CORE_RST_CYCLES(CORE_RST_CYCLES)) u_checker (.*);

// ==== test/dca_mem_model.sv ====
`timescale 1ns/1ps

module dca_mem_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  delay,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [23:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic [7:0]       mem_rdata,
   output logic             mem_ack,
   output logic [7:0]       wr_byte
);
   logic [3:0] wait_cnt;

   // The read bus toggles outside the ack cycle, so a late sample shows up.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wait_cnt <= 4'h0;
         mem_ack <= 1'b0;
         mem_rdata <= 8'h00;
         wr_byte <= 8'h00;
      end
      else if (mem_req && !mem_ack && wait_cnt >= delay)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= mem_addr[7:0] ^ 8'h3c;
         if (mem_we)
            wr_byte <= mem_wdata;
      end
      else
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule : dca_mem_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps

module testbench;
   localparam int RST_CYC = 4;

   logic        clk, rst, dbg_wr, read_done, busy, core_reset_request, core_rst;
   logic        long_address_mode_flag, mem_req, mem_we, mem_ack;
   logic [7:0]  dbg_addr, dbg_wdata, read_result_upper, read_result_high, read_result_low;
   logic [7:0]  mem_wdata, mem_rdata, wr_byte;
   logic [23:0] mem_addr;
   logic [23:0] exp_v [8];
   logic [3:0]  delay;
   int          mismatches, compares;

   dca_access_core #(.CORE_RST_CYCLES(RST_CYC)) dut (.*);

   dca_mem_model u_mem (.*);

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   // The strobe stays high between the bytes of a stream.
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      dbg_wr = 1'b1;
      dbg_addr = a;
      dbg_wdata = d;
      step();
   endtask : put

   // Bounded wait for idle (0), mem_req (1) or read_done (2).
   task automatic await(input int sel);
      int n;
      n = 0;
      while (!(sel == 0 ? busy === 1'b0 : sel == 1 ? mem_req === 1'b1 : read_done === 1'b1))
      begin
         step();
         n++;
         if (n > 40)
         begin
            mismatches++;
            results();
         end
      end
   endtask : await

   task automatic wcmd(input logic [23:0] v, input logic [7:0] c);
      put(8'h13, v[23:16]);
      put(8'h14, v[15:8]);
      put(8'h15, v[7:0]);
      put(8'h16, c);
      dbg_wr = 1'b0;
      step();
   endtask : wcmd

   task automatic rcmd(input logic [7:0] c, input logic [23:0] exp);
      put(8'h16, c);
      dbg_wr = 1'b0;
      step();
      check("read_done", 24'(read_done), 24'h000001);
      check("read result", {read_result_upper, read_result_high, read_result_low}, exp);
   endtask : rcmd

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_registers();
      for (int i = 0; i < 8; i++)
      begin
         exp_v[i] = {8'h10 + 8'(i), 8'hc0 + 8'(i), 8'h5a ^ 8'(i)};
         if (i != 6)
            wcmd(exp_v[i], 8'h80 | 8'(i));
      end
      for (int i = 0; i < 8; i++)
         if (i != 6)
            rcmd(8'(i), exp_v[i]);
      $display("test registers done");
   endtask : t_registers

   task automatic t_stack_mode();
      wcmd(24'h0, 8'h08);
      check("mode set", 24'(long_address_mode_flag), 24'h1);
      wcmd(24'ha1b2c3, 8'h86);
      wcmd(24'h0, 8'h09);
      check("mode clear", 24'(long_address_mode_flag), 24'h0);
      wcmd(24'h123456, 8'h86);
      rcmd(8'h06, 24'h3456);
      wcmd(24'h0, 8'h08);
      rcmd(8'h06, 24'ha1b2c3);
      $display("test stack and mode done");
   endtask : t_stack_mode

   task automatic t_reserved();
      for (int c = 8'h88; c <= 8'h8a; c++)
         wcmd(24'hffffff, 8'(c));
      put(8'h12, 8'h81);
      put(8'h16, 8'h07);
      put(8'h16, 8'h81);
      dbg_wr = 1'b0;
      check("pc", {read_result_upper, read_result_high, read_result_low}, exp_v[7]);
      step();
      rcmd(8'h01, exp_v[1]);
      rcmd(8'h00, exp_v[0]);
      check("mode kept", 24'(long_address_mode_flag), 24'h000001);
      $display("test reserved done");
   endtask : t_reserved

   task automatic t_memory();
      delay = 4'h3;
      wcmd(24'h012345, 8'h87);
      put(8'h16, 8'h0b);
      dbg_wr = 1'b0;
      await(1);
      check("read address", mem_addr, 24'h012345);
      check("read kind", 24'(mem_we), 24'h000000);
      await(2);
      check("memory byte", 24'(read_result_low), 24'h000079);
      await(0);
      rcmd(8'h07, 24'h012346);
      delay = 4'h0;
      wcmd(24'h7e0000, 8'h80);
      wcmd(24'h99fffe, 8'h87);
      wcmd(24'h000000, 8'h09);
      wcmd(24'h00005a, 8'h8b);
      await(1);
      check("write address", mem_addr, 24'h7efffe);
      await(0);
      check("stored byte", 24'(wr_byte), 24'h00005a);
      rcmd(8'h07, 24'h99ffff);
      $display("test memory done");
   endtask : t_memory

   task automatic t_core_reset();
      int n;
      wcmd(24'h0c0d0e, 8'h81);
      wcmd(24'h000000, 8'h08);
      put(8'h11, 8'h7f);
      dbg_wr = 1'b0;
      check("zero write", 24'(core_rst), 24'h000000);
      step();
      put(8'h11, 8'h80);
      dbg_wr = 1'b0;
      n = 0;
      while (core_rst === 1'b1 && n < 20)
      begin
         step();
         n++;
      end
      check("reset length", 24'(n), 24'(RST_CYC));
      if (n == 20)
         results();
      check("request held", 24'(core_reset_request), 24'h000001);
      step();
      check("request cleared", 24'(core_reset_request), 24'h000000);
      await(0);
      rcmd(8'h01, 24'h000000);
      check("mode cleared", 24'(long_address_mode_flag), 24'h000000);
      $display("test core reset done");
   endtask : t_core_reset

   initial
   begin
      rst = 1'b1;
      dbg_wr = 1'b0;
      dbg_addr = 8'h00;
      dbg_wdata = 8'h00;
      delay = 4'h0;
      mismatches = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      check("idle flags", {18'h0, core_reset_request, core_rst, long_address_mode_flag,
                           mem_req, busy, read_done}, 24'h000000);
      rcmd(8'h07, 24'h000000);
      $display("test reset done");
      t_registers();
      t_stack_mode();
      t_reserved();
      t_memory();
      t_core_reset();
      results();
   end
endmodule : testbench
